/* File: dss_top.sv */
/*
 * dss_top: disk-side addressing and sector sequencing for a moving-head
 * cartridge disk controller, write direction. host words pass a fifo
 * and leave as formatted sectors toward the selected drive.
 * assumes: sector, index, seek-ready and write-protect come from the
 * drive pins asynchronously; header words and word-ready come from the
 * serialiser on mclk.
 */
`timescale 1ns/1ps
module dss_top #(
  parameter int FIFO_DEPTH = dss_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [15:0] word_count,
  input wire logic [2:0] drive_num,
  input wire logic [7:0] start_cyl,
  input wire logic start_surface,
  input wire logic [3:0] start_sector,
  input wire logic wlock_req,
  input wire logic dma_valid,
  output logic dma_ready,
  input wire logic [15:0] dma_data,
  input wire logic sector_pin,
  input wire logic index_pin,
  input wire logic seek_ready_pin,
  input wire logic wprot_pin,
  input wire logic hdr_valid,
  input wire logic [15:0] hdr_word,
  input wire logic disk_ready,
  output logic [15:0] disk_word,
  output logic disk_word_valid,
  output logic [7:0] drive_sel,
  output logic [7:0] cyl_addr,
  output logic surface_select,
  output logic [3:0] sector_addr,
  output logic seek_strobe,
  output logic wlock_strobe,
  output logic write_gate,
  output logic busy,
  output logic done,
  output logic [15:0] error_reg
);

  if (FIFO_DEPTH < 2) begin : g_bad
    $error("dss_top: fifo depth too small");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_SEEK, ST_SEEKWAIT, ST_HDR, ST_WSEC, ST_XFER, ST_NEXT
  } dss_state_t;
  typedef enum logic [2:0] {
    FD_PRE, FD_SYNC, FD_HDR, FD_DATA, FD_CSUM, FD_POST
  } dss_field_t;

  dss_state_t state_q;
  dss_field_t field_q;
  logic [dss_pkg::NUM_PINS-1:0] pin_raw;
  logic [dss_pkg::NUM_PINS-1:0] s1_q;
  logic [dss_pkg::NUM_PINS-1:0] s2_q;
  logic [dss_pkg::NUM_PINS-1:0] s3_q;
  logic [dss_pkg::NUM_PINS-1:0] filt_q;
  logic [dss_pkg::NUM_PINS-1:0] rise;
  logic [2:0] drive_q;
  logic [7:0] cyl_q;
  logic sur_q;
  logic [3:0] sec_q;
  logic [3:0] sect_cnt_q;
  logic idx_seen_q;
  logic [16:0] left_q;
  logic [4:0] tries_q;
  logic [8:0] fcnt_q;
  logic [15:0] csum_q;
  logic [15:0] err_q;
  logic f_valid;
  logic f_ready;
  logic [15:0] f_data;
  logic word_go;
  logic hdr_ok;
  logic [15:0] hdr_out;

  // ----------------------------------------------------------------
  // pin synchronisers: a change counts once stages two and three agree
  // ----------------------------------------------------------------
  assign pin_raw = {wprot_pin, seek_ready_pin, index_pin, sector_pin};
  for (genvar i = 0; i < dss_pkg::NUM_PINS; i++) begin : g_sync
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
        filt_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin_raw[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          filt_q[i] <= s3_q[i];
        end
      end
    end
    assign rise[i] = s2_q[i] && s3_q[i] && !filt_q[i];
  end

  // ----------------------------------------------------------------
  // data buffer between host and disk
  // ----------------------------------------------------------------
  dss_fifo #(
    .WIDTH(dss_pkg::WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(dma_valid),
    .in_ready(dma_ready),
    .in_data(dma_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // a word leaves when the serialiser wants one and data is at hand
  assign word_go = (state_q == ST_XFER) && disk_ready &&
                   ((field_q != FD_DATA) || (left_q == '0) || f_valid);
  assign f_ready = word_go && (field_q == FD_DATA) && (left_q != '0);
  assign hdr_ok = (hdr_word[dss_pkg::HDR_CYL_LSB +: dss_pkg::CYL_W] ==
                   cyl_q);
  assign hdr_out = {3'h0, cyl_q, sur_q, sec_q};

  // ----------------------------------------------------------------
  // rotational position: sector counter from sector and index pulses
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sect_cnt_q <= 4'h0;
      idx_seen_q <= 1'b0;
    end else begin
      if (rise[dss_pkg::PIN_SECTOR]) begin
        idx_seen_q <= 1'b0;
        if (idx_seen_q || sect_cnt_q == dss_pkg::LAST_SEC) begin
          sect_cnt_q <= 4'h0;
        end else begin
          sect_cnt_q <= sect_cnt_q + 4'h1;
        end
      end
      if (rise[dss_pkg::PIN_INDEX]) begin
        idx_seen_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequencer: seek, header check, sector wait, transfer, advance
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      drive_q <= 3'h0;
      cyl_q <= 8'h00;
      sur_q <= 1'b0;
      sec_q <= 4'h0;
      left_q <= '0;
      tries_q <= 5'h00;
      err_q <= dss_pkg::ERR_RESET;
      done <= 1'b0;
      seek_strobe <= 1'b0;
    end else begin
      done <= 1'b0;
      seek_strobe <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            drive_q <= drive_num;
            cyl_q <= start_cyl;
            sur_q <= start_surface;
            sec_q <= start_sector;
            left_q <= (word_count == 16'h0000) ? 17'h10000 :
                      {1'b0, word_count};
            err_q <= dss_pkg::ERR_RESET;
            tries_q <= 5'h00;
            if (start_cyl > dss_pkg::LAST_CYL ||
                start_sector > dss_pkg::LAST_SEC) begin
              err_q[dss_pkg::ERR_OVR_BIT] <= 1'b1;
              done <= 1'b1;
            end else if (filt_q[dss_pkg::PIN_WPROT]) begin
              err_q[dss_pkg::ERR_WLOCK_BIT] <= 1'b1;
              done <= 1'b1;
            end else begin
              state_q <= ST_SEEK;
            end
          end
        end
        ST_SEEK: begin
          seek_strobe <= 1'b1;
          tries_q <= tries_q + 5'h01;
          state_q <= ST_SEEKWAIT;
        end
        ST_SEEKWAIT: begin
          if (!seek_strobe && filt_q[dss_pkg::PIN_SEEKRDY]) begin
            state_q <= ST_HDR;
          end
        end
        ST_HDR: begin
          if (hdr_valid) begin
            if (hdr_ok) begin
              tries_q <= 5'h00;
              state_q <= ST_WSEC;
            end else if (tries_q == dss_pkg::SEEK_TRIES) begin
              err_q[dss_pkg::ERR_SEEK_BIT] <= 1'b1;
              done <= 1'b1;
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_SEEK;
            end
          end
        end
        ST_WSEC: begin
          if (rise[dss_pkg::PIN_SECTOR] &&
              (idx_seen_q ? 4'h0 : sect_cnt_q + 4'h1) == sec_q) begin
            state_q <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (f_ready) begin
            left_q <= left_q - 17'h00001;
          end
          if (word_go && field_q == FD_POST) begin
            state_q <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (sec_q != dss_pkg::LAST_SEC) begin
            sec_q <= sec_q + 4'h1;
          end else begin
            sec_q <= 4'h0;
          end
          if (left_q == '0) begin
            done <= 1'b1;
            state_q <= ST_IDLE;
          end else if (sec_q != dss_pkg::LAST_SEC) begin
            state_q <= ST_WSEC;
          end else if (!sur_q) begin
            sur_q <= 1'b1;
            state_q <= ST_WSEC;
          end else if (cyl_q == dss_pkg::LAST_CYL) begin
            err_q[dss_pkg::ERR_OVR_BIT] <= 1'b1;
            done <= 1'b1;
            state_q <= ST_IDLE;
          end else begin
            sur_q <= 1'b0;
            cyl_q <= cyl_q + 8'h01;
            state_q <= ST_SEEK;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sector formatter: field sequence and checksum
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      field_q <= FD_PRE;
      fcnt_q <= 9'h000;
      csum_q <= 16'h0000;
      disk_word <= 16'h0000;
      disk_word_valid <= 1'b0;
    end else begin
      disk_word_valid <= word_go;
      if (state_q != ST_XFER) begin
        field_q <= FD_PRE;
        fcnt_q <= 9'h000;
        csum_q <= 16'h0000;
      end else if (word_go) begin
        fcnt_q <= fcnt_q + 9'h001;
        case (field_q)
          FD_PRE: begin
            disk_word <= dss_pkg::FILL_WORD;
            // the thirteenth preamble word is the one with the sync bit
            if (fcnt_q == dss_pkg::PRE_WORDS - 9'h002) begin
              field_q <= FD_SYNC;
            end
          end
          FD_SYNC: begin
            disk_word <= dss_pkg::SYNC_WORD;
            field_q <= FD_HDR;
          end
          FD_HDR: begin
            disk_word <= hdr_out;
            fcnt_q <= 9'h000;
            field_q <= FD_DATA;
          end
          FD_DATA: begin
            disk_word <= (left_q != '0) ? f_data : dss_pkg::FILL_WORD;
            csum_q <= csum_q + ((left_q != '0) ? f_data : 16'h0000);
            if (fcnt_q == dss_pkg::DATA_WORDS - 9'h001) begin
              field_q <= FD_CSUM;
            end
          end
          FD_CSUM: begin
            disk_word <= csum_q;
            field_q <= FD_POST;
          end
          FD_POST: begin
            disk_word <= dss_pkg::FILL_WORD;
          end
          default: begin
            field_q <= FD_PRE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // drive outputs: one-hot select, address, write lock, status
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      drive_sel <= 8'h00;
      cyl_addr <= 8'h00;
      surface_select <= 1'b0;
      sector_addr <= 4'h0;
      wlock_strobe <= 1'b0;
      write_gate <= 1'b0;
      busy <= 1'b0;
      error_reg <= dss_pkg::ERR_RESET;
    end else begin
      drive_sel <= 8'h01 << drive_q;
      cyl_addr <= cyl_q;
      surface_select <= sur_q;
      sector_addr <= sec_q;
      wlock_strobe <= wlock_req && (state_q == ST_IDLE);
      write_gate <= (state_q == ST_XFER);
      busy <= (state_q != ST_IDLE) || start;
      error_reg <= err_q;
    end
  end

endmodule : dss_top

/* File: dss_pkg.sv */
/*
 * dss_pkg: constants of the disk sector sequencer (geometry, sector
 * format, header and error bit layout, fifo defaults).
 * assumes: used by dss_top through scoped names only.
 */
package dss_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_DRIVES = 8;
  localparam int DRV_W = 3;
  localparam int NUM_CYL = 203;
  localparam int CYL_W = 8;
  localparam logic [7:0] LAST_CYL = 8'hCA;
  localparam int SEC_W = 4;
  localparam logic [3:0] LAST_SEC = 4'hB;
  localparam int WORD_W = 16;
  localparam int WC_W = 17;

  // ----------------------------------------------------------------
  // sector format, in words
  // ----------------------------------------------------------------
  localparam logic [8:0] PRE_WORDS = 9'h00D;
  localparam logic [8:0] DATA_WORDS = 9'h100;
  localparam logic [15:0] SYNC_WORD = 16'h0001;
  localparam logic [15:0] FILL_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // header word layout: cylinder, surface, sector
  // ----------------------------------------------------------------
  localparam int HDR_CYL_LSB = 5;
  localparam int HDR_SUR_BIT = 4;
  localparam int HDR_SEC_LSB = 0;

  // ----------------------------------------------------------------
  // error register bits and retries
  // ----------------------------------------------------------------
  localparam int ERR_SEEK_BIT = 12;
  localparam int ERR_WLOCK_BIT = 13;
  localparam int ERR_OVR_BIT = 14;
  localparam logic [4:0] SEEK_TRIES = 5'h10;
  localparam logic [15:0] ERR_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // input synchroniser slots and fifo defaults
  // ----------------------------------------------------------------
  localparam int PIN_SECTOR = 0;
  localparam int PIN_INDEX = 1;
  localparam int PIN_SEEKRDY = 2;
  localparam int PIN_WPROT = 3;
  localparam int NUM_PINS = 4;
  localparam int FIFO_DEPTH = 16;

endpackage : dss_pkg

/* File: dss_fifo.sv */
/*
 * dss_fifo: first-word-fall-through fifo, valid/ready on both sides,
 * registered full and empty flags.
 * assumes: one clock, asynchronous active-low reset, depth a power of 2.
 */
`timescale 1ns/1ps
module dss_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("dss_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic empty_q;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_ready && !empty_q;
  assign out_valid = !empty_q;
  assign out_data = mem[rd_ptr_q];

  // occupancy after this cycle's push and pop
  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + (AW+1)'(1);
    end else if (pop && !push) begin
      count_d = count_q - (AW+1)'(1);
    end
  end

  // storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // pointers and flags
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      count_q <= count_d;
      in_ready <= (count_d != (AW+1)'(DEPTH));
      empty_q <= (count_d == '0);
    end
  end

endmodule : dss_fifo

/* File: dss_top_assertions.sv */
/*
 * dss_top_chk: port-level properties of the disk sector sequencer.
 * assumes: bound onto dss_top below, one clock domain on mclk.
 */
`timescale 1ns/1ps
module dss_top_chk (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [7:0] start_cyl,
  input wire logic [3:0] start_sector,
  input wire logic busy,
  input wire logic done,
  input wire logic seek_strobe,
  input wire logic write_gate,
  input wire logic [7:0] drive_sel,
  input wire logic [7:0] cyl_addr,
  input wire logic surface_select,
  input wire logic [3:0] sector_addr,
  input wire logic disk_ready,
  input wire logic disk_word_valid,
  input wire logic [15:0] error_reg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // start handling
  // ----------------------------------------------------------------
  sequence s_take;
    start && !busy;
  endsequence
  sequence s_bad;
    s_take ##0 (start_cyl > 8'hCA || start_sector > 4'hB);
  endsequence
  property p_answer;
    s_take |=> busy || done;
  endproperty
  a_answer: assert property (p_answer) else $error("start not answered");
  property p_refuse;
    s_bad |=> done ##1 error_reg[14];
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad address taken");
  property p_seek;
    $rose(busy) && !done |=> seek_strobe;
  endproperty
  a_seek: assert property (p_seek) else $error("no implied seek");
  property p_done;
    done |=> !done;
  endproperty
  a_done: assert property (p_done) else $error("done longer than a cycle");
  // ----------------------------------------------------------------
  // addressing and transfer
  // ----------------------------------------------------------------
  property p_sel;
    write_gate |-> $onehot(drive_sel);
  endproperty
  a_sel: assert property (p_sel) else $error("drive select not one-hot");
  property p_range;
    write_gate |-> sector_addr <= 4'hB && cyl_addr <= 8'hCA;
  endproperty
  a_range: assert property (p_range) else $error("address out of range");
  property p_pace;
    disk_word_valid |-> $past(disk_ready);
  endproperty
  a_pace: assert property (p_pace) else $error("word without ready");
  property p_sur;
    $rose(surface_select) && $past(busy, 2) |-> sector_addr == 4'h0;
  endproperty
  a_sur: assert property (p_sur) else $error("surface change off wrap");
  property p_cyl;
    cyl_addr != $past(cyl_addr) && $past(busy, 2) |->
      cyl_addr == $past(cyl_addr) + 8'h01 && !surface_select;
  endproperty
  a_cyl: assert property (p_cyl) else $error("bad cylinder step");
  property p_ovr;
    $rose(error_reg[14]) |=> !write_gate && !seek_strobe && !busy;
  endproperty
  a_ovr: assert property (p_ovr) else $error("runs on after overflow");
  property p_seekerr;
    error_reg[12] |=> !write_gate;
  endproperty
  a_seekerr: assert property (p_seekerr) else $error("writes after seek error");
endmodule : dss_top_chk

bind dss_top dss_top_chk u_chk (.mclk(mclk), .resetn(resetn), .start(start),
  .start_cyl(start_cyl), .start_sector(start_sector), .busy(busy),
  .done(done), .seek_strobe(seek_strobe), .write_gate(write_gate),
  .drive_sel(drive_sel), .cyl_addr(cyl_addr), .sector_addr(sector_addr),
  .surface_select(surface_select), .disk_ready(disk_ready),
  .disk_word_valid(disk_word_valid), .error_reg(error_reg));

/* File: dss_drive_model.sv */
/*
 * dss_drive_model: behavioural chained drive and serialiser.
 * assumes: driven by the bench, clocked by mclk of the sequencer.
 */
`timescale 1ns/1ps
module dss_drive_model #(
  parameter int SEC_CYC = 360,
  parameter int SEEK_CYC = 40
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic seek_strobe,
  input wire logic wlock_strobe,
  input wire logic [7:0] cyl_addr,
  input wire logic bad_hdr,
  input wire logic slow,
  input wire logic manual_wp,
  input wire logic wp_clear,
  output logic sector_pin,
  output logic index_pin,
  output logic seek_ready_pin,
  output logic wprot_pin,
  output logic hdr_valid,
  output logic [15:0] hdr_word,
  output logic disk_ready,
  output logic [3:0] cur_sec
);
  logic [9:0] cnt_q;
  logic [7:0] head_q;
  logic [7:0] seek_q;
  logic wp_q;
  // sector timer; the number advances at each sector pulse
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 10'h000;
      cur_sec <= 4'hB;
    end else begin
      cnt_q <= (cnt_q == 10'(SEC_CYC - 1)) ? 10'h000 : cnt_q + 10'h001;
      if (cnt_q == 10'(SEC_CYC - 1)) begin
        cur_sec <= (cur_sec == 4'hB) ? 4'h0 : cur_sec + 4'h1;
      end
    end
  end
  // pulses: sector opens each sector, index lies inside the last one
  assign sector_pin = cnt_q < 10'h004;
  assign index_pin = cur_sec == 4'hB && cnt_q[9:2] == 8'h20;
  assign disk_ready = !slow || cnt_q[2:0] != 3'h0;
  // head positioner and write lock latch
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      head_q <= 8'h00;
      seek_q <= 8'h00;
      wp_q <= 1'b0;
    end else begin
      if (seek_strobe) begin
        head_q <= cyl_addr;
        seek_q <= 8'(SEEK_CYC);
      end else if (seek_q != 8'h00) begin
        seek_q <= seek_q - 8'h01;
      end
      if (wlock_strobe) begin
        wp_q <= 1'b1;
      end else if (wp_clear) begin
        wp_q <= 1'b0;
      end
    end
  end
  assign seek_ready_pin = seek_q == 8'h00;
  assign wprot_pin = wp_q || manual_wp;
  // header read after each pulse once no seek is running; the bus toggles between reads
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hdr_valid <= 1'b0;
      hdr_word <= 16'h0000;
    end else begin
      hdr_valid <= cnt_q == 10'h008 && seek_q == 8'h00;
      if (cnt_q == 10'h008) begin
        hdr_word <= {3'h0, head_q + {7'h00, bad_hdr}, 1'b0, cur_sec};
      end else begin
        hdr_word <= ~hdr_word;
      end
    end
  end
endmodule : dss_drive_model

/* File: dss_top_test.sv */
/*
 * dss_top_test: self-checking bench for the disk sector sequencer.
 * assumes: dss_top, dss_fifo, dss_drive_model and the checker compiled.
 */
`timescale 1ns/1ps
module dss_top_test;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic [15:0] word_count = 16'h0000;
  logic [2:0] drive_num = 3'h0;
  logic [7:0] start_cyl = 8'h00;
  logic start_surface = 1'b0;
  logic [3:0] start_sector = 4'h0;
  logic wlock_req = 1'b0;
  logic dma_valid = 1'b0;
  logic [15:0] dma_data = 16'h0000;
  logic bad_hdr = 1'b0, slow = 1'b0, manual_wp = 1'b0, wp_clear = 1'b0;
  wire dma_ready, sector_pin, index_pin, seek_ready_pin, wprot_pin;
  wire hdr_valid, disk_ready, disk_word_valid, surface_select, busy, done;
  wire seek_strobe, wlock_strobe, write_gate;
  wire [15:0] hdr_word, disk_word, error_reg;
  wire [7:0] drive_sel, cyl_addr;
  wire [3:0] sector_addr, cur_sec;
  int mismatches = 0, check_count = 0, cycles = 0;
  int n_send = 0, sent = 0, left = 0, idx = 0, seeks = 0;
  logic [31:0] seed = 32'hA4FAF6AA;
  logic [15:0] dq[$];
  logic [15:0] sum, ew;
  logic [12:0] ea;
  logic [2:0] edrv;
  logic acc = 1'b0;

  always #4 mclk = ~mclk;

  dss_top #(.FIFO_DEPTH(16)) uut (.mclk(mclk), .resetn(resetn),
    .start(start), .word_count(word_count), .drive_num(drive_num),
    .start_cyl(start_cyl), .start_surface(start_surface),
    .start_sector(start_sector), .wlock_req(wlock_req),
    .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_data(dma_data),
    .sector_pin(sector_pin), .index_pin(index_pin),
    .seek_ready_pin(seek_ready_pin), .wprot_pin(wprot_pin),
    .hdr_valid(hdr_valid), .hdr_word(hdr_word), .disk_ready(disk_ready),
    .disk_word(disk_word), .disk_word_valid(disk_word_valid),
    .drive_sel(drive_sel), .cyl_addr(cyl_addr), .done(done),
    .surface_select(surface_select), .sector_addr(sector_addr),
    .seek_strobe(seek_strobe), .wlock_strobe(wlock_strobe),
    .write_gate(write_gate), .busy(busy), .error_reg(error_reg));

  dss_drive_model drive (.mclk(mclk), .resetn(resetn),
    .seek_strobe(seek_strobe), .wlock_strobe(wlock_strobe),
    .cyl_addr(cyl_addr), .bad_hdr(bad_hdr), .slow(slow),
    .manual_wp(manual_wp), .wp_clear(wp_clear), .sector_pin(sector_pin),
    .index_pin(index_pin), .seek_ready_pin(seek_ready_pin),
    .wprot_pin(wprot_pin), .hdr_valid(hdr_valid), .hdr_word(hdr_word),
    .disk_ready(disk_ready), .cur_sec(cur_sec));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd_next(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : rnd_next

  // next {cylinder, surface, sector} after a finished sector
  function automatic logic [12:0] next_addr(input logic [12:0] a);
    if (a[3:0] != 4'hB) return a + 13'h0001;
    if (!a[4]) return {a[12:5], 1'b1, 4'h0};
    return {a[12:5] + 8'h01, 1'b0, 4'h0};
  endfunction : next_addr

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task end_of_test;
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // one start, then wait for done and compare the outcome
  task automatic run(input logic [2:0] d, input logic [12:0] a,
      input logic [15:0] n, input int ns, input logic [15:0] eerr);
    int k;
    @(negedge mclk);
    start = 1'b1;
    drive_num = d;
    {start_cyl, start_surface, start_sector} = a;
    word_count = n;
    ea = a;
    edrv = d;
    left = n;
    idx = 0;
    sum = 16'h0000;
    seeks = 0;
    sent = 0;
    n_send = ns;
    @(negedge mclk);
    start = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 30000) begin
      @(negedge mclk);
      k++;
    end
    if (done !== 1'b1) mismatches++;
    // error_reg follows the internal flags one cycle after done
    @(negedge mclk);
    if (eerr == 16'hFFFF) check({15'h0, error_reg != 16'h0}, 16'h0001);
    else check(error_reg, eerr);
    if (eerr == 16'h0000) check(left[15:0], 16'h0000);
  endtask : run

  // ----------------------------------------------------------------
  // host word stream and disk word monitor
  // ----------------------------------------------------------------
  always @(posedge mclk) acc = dma_valid && dma_ready;

  // host side: hold a word until it is taken, then offer the next
  always @(negedge mclk) begin
    if (acc) begin
      dq.push_back(dma_data);
      sent++;
      seed = rnd_next(seed);
      dma_data = seed[15:0];
    end
    dma_valid = sent < n_send;
  end

  // disk side: rebuild each sector from expectations and compare
  always @(negedge mclk) begin
    if (seek_strobe) seeks++;
    if (disk_word_valid) begin
      ew = 16'h0000;
      if (idx == 0) check({8'h00, drive_sel}, 16'(8'h01 << edrv));
      if (idx == 0) check({12'h000, cur_sec}, {12'h000, ea[3:0]});
      if (idx == 12) ew = 16'h0001;
      if (idx == 13) ew = {3'h0, ea};
      if (idx > 13 && idx < 270 && left > 0 && dq.size() > 0) begin
        ew = dq.pop_front();
        left--;
        sum = sum + ew;
      end
      if (idx == 270) ew = sum;
      check(disk_word, ew);
      idx = (idx == 271) ? 0 : idx + 1;
      if (idx == 0) begin
        sum = 16'h0000;
        ea = next_addr(ea);
      end
    end
  end

  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 99000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge mclk);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    run(3'h0, {8'h00, 1'b0, 4'h3}, 16'h0001, 1, 16'h0000);
    run(3'h3, {8'h05, 1'b0, 4'hB}, 16'h012C, 300, 16'h0000);
    slow = 1'b1;
    run(3'h7, {8'h05, 1'b1, 4'hB}, 16'h0101, 257, 16'h0000);
    slow = 1'b0;
    run(3'h2, {8'hCA, 1'b1, 4'hB}, 16'h012C, 256, 16'h4000);
    bad_hdr = 1'b1;
    run(3'h1, {8'h0A, 1'b0, 4'h0}, 16'h0004, 0, 16'h1000);
    check(seeks[15:0], 16'h0010);
    bad_hdr = 1'b0;
    run(3'h4, {8'hCB, 1'b0, 4'h0}, 16'h0001, 0, 16'hFFFF);
    run(3'h4, {8'h00, 1'b0, 4'hC}, 16'h0001, 0, 16'hFFFF);
    wlock_req = 1'b1;
    @(negedge mclk);
    wlock_req = 1'b0;
    repeat (8) @(negedge mclk);
    run(3'h5, {8'h01, 1'b0, 4'h0}, 16'h0001, 0, 16'h2000);
    wp_clear = 1'b1;
    manual_wp = 1'b1;
    repeat (8) @(negedge mclk);
    wp_clear = 1'b0;
    run(3'h5, {8'h01, 1'b0, 4'h0}, 16'h0001, 0, 16'h2000);
    manual_wp = 1'b0;
    repeat (8) @(negedge mclk);
    repeat (3) begin
      seed = rnd_next(seed);
      run(seed[2:0], {8'(seed[15:8] % 202), seed[16], 4'(seed[20:17] % 12)},
        16'(seed[29:21]) + 16'h0001, int'(seed[29:21]) + 1, 16'h0000);
    end
    end_of_test();
  end
endmodule : dss_top_test
